// ==== acs_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module acs_core_model (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // From the sequencer
    input wire logic        core_enable,
    input wire logic        conv_start,
    input wire logic [3:0]  analog_input_channel,
    input wire logic        slow,
    // Result
    output logic            conv_done,
    output logic [11:0]     conv_data
);
    logic [3:0] ch_r;
    logic [3:0] cnt_r;
    logic       busy_r;
    // Data toggles outside the done cycle so a late sample cannot match by luck
    always_ff @(posedge aclk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (!aresetn) begin
            busy_r    <= 1'b0;
            conv_data <= 12'h555;
        end else if (!core_enable) begin
            busy_r <= 1'b0;
        end else if (conv_start) begin
            busy_r <= 1'b1;
            ch_r   <= analog_input_channel;
            cnt_r  <= slow ? 4'h9 : 4'h1;
        end else if (busy_r) begin
            if (cnt_r == 4'h0) begin
                busy_r    <= 1'b0;
                conv_done <= 1'b1;
                conv_data <= 12'h0A0 + {8'h00, ch_r};
            end else cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== acs_pkg.sv ====
`default_nettype none
package acs_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL0  = 8'h00;
    localparam logic [7:0] ADDR_START  = 8'h04;
    localparam logic [7:0] ADDR_CTRL2  = 8'h08;
    localparam logic [7:0] ADDR_SEQLEN = 8'h0C;
    localparam logic [7:0] ADDR_SLOTS  = 8'h10;
    localparam logic [7:0] ADDR_FLAG   = 8'h14;
    localparam logic [7:0] ADDR_FCLR   = 8'h18;
    localparam logic [7:0] ADDR_IEN    = 8'h1C;
    localparam logic [7:0] ADDR_RES0   = 8'h20;
    localparam logic [7:0] ADDR_ACC    = 8'h40;
    // Field positions
    localparam int CTRL0_EN      = 0;
    localparam int CTRL0_SAM_LSB = 2;
    localparam int CTRL0_MOD_LSB = 4;
    localparam int START_GO      = 0;
    localparam int START_AUTO    = 1;
    localparam int CTRL2_ACCUMULATE_ENABLE   = 0;
    localparam int CTRL2_ACCUMULATOR_RESET  = 1;
    localparam int CTRL2_CNT_LSB = 8;
    localparam int FLAG_READY    = 0;
    localparam int FLAG_EOC      = 1;
    localparam int FLAG_EOS      = 2;
    localparam int FLAG_EOA      = 3;
    // Reset values
    localparam logic [31:0] SLOTS_RST = 32'h0000_0000;
    localparam logic [2:0]  SEQ_RST   = 3'h0;
    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Converter start-up time
    localparam int CLK_PERIOD_NS = 8;
    localparam int STARTUP_NS    = 1000;
    localparam int STARTUP_CYC   = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        MODE_SGL_ONE  = 3'h0,
        MODE_SGL_MULT = 3'h1,
        MODE_SGL_CONT = 3'h2,
        MODE_SEQ_SCAN = 3'h3,
        MODE_SEQ_CONT = 3'h4,
        MODE_SEQ_MULT = 3'h5,
        MODE_SEQ_INTR = 3'h6
    } acs_mode_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'h0,
        ST_CONV = 1'h1
    } acs_state_type;
endpackage
`default_nettype wire

// ==== acs_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module acs_properties import acs_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Converter side
    input wire logic core_enable,
    input wire logic conv_start
);
    // Cycles since enable; saturates so a long run cannot wrap back below start-up
    logic [7:0] en_cyc_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || !core_enable) en_cyc_r <= 8'h00;
        else if (en_cyc_r != 8'hFF) en_cyc_r <= en_cyc_r + 8'h01;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answered: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready
        |=> s_axi_bvalid) else $error("write not answered");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while answer pending");
    a_read_answered: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped early");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    a_start_enabled: assert property (conv_start |-> core_enable && en_cyc_r >= STARTUP_CYC)
        else $error("conversion started before start-up");
endmodule
bind acs_top acs_properties i_props (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .core_enable(core_enable),
    .conv_start(conv_start)
);
`default_nettype wire

// ==== acs_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module acs_top import acs_pkg::*; #(
    parameter int CH_W  = 4,
    parameter int RES_W = 12,
    parameter int ACC_W = 24,
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // Converter core and channel multiplexer
    output logic                  core_enable,
    output logic                  conv_start,
    output logic [CH_W-1:0]       analog_input_channel,
    output logic [1:0]            sampling_speed,
    input  wire logic             conv_done,
    input  wire logic [RES_W-1:0] conv_data,
    // Interrupt request
    output logic                  irq
);
    localparam int SLOTS = 8;

    acs_state_type     state_r;
    acs_mode_type      mode_r;
    logic              en_r, go_r, auto_r, ready_r;
    logic              accumulate_enable_r;
    logic [CNT_W-1:0]  conversion_count_r, done_cnt_r;
    logic [2:0]        sequence_length_r, slot_r;
    logic [31:0]       slots_r;
    logic [3:1]        flag_r, ien_r;
    logic [15:0]       boot_cnt_r;
    logic [RES_W-1:0]  slot_result_r [SLOTS];
    logic [ACC_W-1:0]  result_accumulator_r;

    logic              wr_fire, rd_fire;
    logic [7:0]        waddr, raddr;
    logic              wr_ok, rd_ok;
    logic [31:0]       rd_mux;
    logic              done_hit, seq_mode, multi_mode, cont_mode;
    logic              last_slot, total_hit, job_end, drop_en, launch;
    logic [2:0]        next_slot, first_slot;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [CH_W-1:0] chan_of(input logic [31:0] s,
                                                input logic [2:0]  idx);
        return s[idx*4 +: CH_W];
    endfunction

    // Bus slave: address and data taken together, one answer outstanding
    assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid && !s_axi_rvalid;
    assign waddr         = {s_axi_awaddr[7:2], 2'h0};
    assign raddr         = {s_axi_araddr[7:2], 2'h0};

    always_comb begin
        case (waddr)
            ADDR_CTRL0, ADDR_START, ADDR_CTRL2, ADDR_SEQLEN,
            ADDR_SLOTS, ADDR_FCLR, ADDR_IEN: wr_ok = 1'b1;
            default:                         wr_ok = 1'b0;
        endcase
    end

    always_comb begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0000_0000;
        case (raddr)
            ADDR_CTRL0: begin
                rd_mux[CTRL0_EN]                   = en_r;
                rd_mux[CTRL0_SAM_LSB +: 2]         = sampling_speed;
                rd_mux[CTRL0_MOD_LSB +: 3]         = mode_r;
            end
            ADDR_START: begin
                rd_mux[START_GO]                   = go_r;
                rd_mux[START_AUTO]                 = auto_r;
            end
            ADDR_CTRL2: begin
                rd_mux[CTRL2_ACCUMULATE_ENABLE]                = accumulate_enable_r;
                rd_mux[CTRL2_CNT_LSB +: CNT_W]     = conversion_count_r;
            end
            ADDR_SEQLEN: rd_mux[2:0]               = sequence_length_r;
            ADDR_SLOTS:  rd_mux                    = slots_r;
            ADDR_FLAG:   rd_mux[3:0]               = {flag_r, ready_r};
            ADDR_FCLR:   rd_mux                    = 32'h0000_0000;
            ADDR_IEN:    rd_mux[3:1]               = ien_r;
            ADDR_ACC:    rd_mux[ACC_W-1:0]         = result_accumulator_r;
            default: begin
                if (raddr[7:5] == ADDR_RES0[7:5]) begin
                    rd_mux[RES_W-1:0] = slot_result_r[raddr[4:2]];
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Sequencing decisions, evaluated on the cycle a result returns
    assign done_hit   = (state_r == ST_CONV) && conv_done;
    assign seq_mode   = (mode_r == MODE_SEQ_SCAN) || (mode_r == MODE_SEQ_CONT) ||
                        (mode_r == MODE_SEQ_MULT) || (mode_r == MODE_SEQ_INTR);
    assign multi_mode = (mode_r == MODE_SGL_MULT) || (mode_r == MODE_SEQ_MULT);
    assign cont_mode  = (mode_r == MODE_SGL_CONT) || (mode_r == MODE_SEQ_CONT);
    // Compare with >= so a shortened sequence cannot strand the pointer
    assign last_slot  = !seq_mode || (slot_r >= sequence_length_r);
    assign next_slot  = last_slot ? 3'h0 : slot_r + 3'h1;
    assign total_hit  = (done_cnt_r == conversion_count_r);
    assign first_slot = (mode_r == MODE_SEQ_INTR) ? slot_r : 3'h0;

    always_comb begin
        case (mode_r)
            MODE_SGL_ONE:  job_end = 1'b1;
            MODE_SEQ_SCAN: job_end = last_slot;
            MODE_SGL_MULT,
            MODE_SEQ_MULT: job_end = total_hit;
            MODE_SGL_CONT,
            MODE_SEQ_CONT: job_end = !go_r;
            MODE_SEQ_INTR: job_end = 1'b1;
            default:       job_end = 1'b1;
        endcase
    end

    // Intermittent mode only powers down after the final slot
    assign drop_en = done_hit && job_end && auto_r &&
                     ((mode_r != MODE_SEQ_INTR) || last_slot);
    assign launch  = (state_r == ST_IDLE) && go_r && en_r && ready_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r              <= ST_IDLE;
            conv_start           <= 1'b0;
            analog_input_channel <= '0;
            slot_r               <= 3'h0;
            done_cnt_r           <= '0;
        end else begin
            conv_start <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (!en_r) begin
                        slot_r <= 3'h0;
                    end else if (launch) begin
                        state_r              <= ST_CONV;
                        conv_start           <= 1'b1;
                        slot_r               <= first_slot;
                        analog_input_channel <= chan_of(slots_r, first_slot);
                        done_cnt_r           <= '0;
                    end
                end
                ST_CONV: begin
                    if (!en_r) begin
                        state_r <= ST_IDLE;
                    end else if (done_hit) begin
                        done_cnt_r <= done_cnt_r + 1'b1;
                        slot_r     <= next_slot;
                        if (job_end) begin
                            state_r <= ST_IDLE;
                        end else begin
                            conv_start           <= 1'b1;
                            analog_input_channel <= chan_of(slots_r, next_slot);
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Software enable; a write in the same cycle as auto-off wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_r           <= 1'b0;
            mode_r         <= MODE_SGL_ONE;
            sampling_speed <= 2'h0;
        end else if (wr_fire && waddr == ADDR_CTRL0) begin
            en_r           <= s_axi_wstrb[0] ? s_axi_wdata[CTRL0_EN]
                                             : en_r;
            mode_r         <= acs_mode_type'(s_axi_wdata[CTRL0_MOD_LSB +: 3] &
                                             {3{s_axi_wstrb[0]}} |
                                             mode_r & {3{!s_axi_wstrb[0]}});
            sampling_speed <= s_axi_wstrb[0] ? s_axi_wdata[CTRL0_SAM_LSB +: 2]
                                             : sampling_speed;
        end else if (drop_en) begin
            en_r <= 1'b0;
        end
    end
    assign core_enable = en_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            go_r   <= 1'b0;
            auto_r <= 1'b0;
        end else if (wr_fire && waddr == ADDR_START && s_axi_wstrb[0]) begin
            go_r   <= s_axi_wdata[START_GO];
            auto_r <= s_axi_wdata[START_AUTO];
        end else if (done_hit && job_end) begin
            go_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            accumulate_enable_r            <= 1'b0;
            conversion_count_r <= '0;
            sequence_length_r  <= SEQ_RST;
            slots_r            <= SLOTS_RST;
            ien_r              <= 3'h0;
        end else if (wr_fire) begin
            case (waddr)
                ADDR_CTRL2: begin
                    if (s_axi_wstrb[0]) begin
                        accumulate_enable_r <= s_axi_wdata[CTRL2_ACCUMULATE_ENABLE];
                    end
                    if (s_axi_wstrb[1]) begin
                        conversion_count_r <= s_axi_wdata[CTRL2_CNT_LSB +: CNT_W];
                    end
                end
                ADDR_SEQLEN: begin
                    if (s_axi_wstrb[0]) begin
                        sequence_length_r <= s_axi_wdata[2:0];
                    end
                end
                ADDR_SLOTS: slots_r <= merge(slots_r, s_axi_wdata, s_axi_wstrb);
                ADDR_IEN: begin
                    if (s_axi_wstrb[0]) begin
                        ien_r <= s_axi_wdata[3:1];
                    end
                end
                default: ;
            endcase
        end
    end

    // Start-up delay before the core may convert
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot_cnt_r <= 16'h0000;
            ready_r    <= 1'b0;
        end else if (!en_r) begin
            boot_cnt_r <= 16'h0000;
            ready_r    <= 1'b0;
        end else if (!ready_r) begin
            boot_cnt_r <= boot_cnt_r + 16'h0001;
            ready_r    <= (boot_cnt_r == 16'(STARTUP_CYC - 1));
        end
    end

    generate
        for (genvar i = 0; i < SLOTS; i++) begin : g_res
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    slot_result_r[i] <= '0;
                end else if (done_hit && slot_r == 3'(i)) begin
                    slot_result_r[i] <= conv_data;
                end
            end
        end
    endgenerate

    // Reset strobe coinciding with a result restarts the sum from that result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_accumulator_r <= '0;
        end else if (wr_fire && waddr == ADDR_CTRL2 && s_axi_wstrb[0] &&
                     s_axi_wdata[CTRL2_ACCUMULATOR_RESET]) begin
            result_accumulator_r <= (done_hit && accumulate_enable_r) ?
                                    ACC_W'(conv_data) : '0;
        end else if (done_hit && accumulate_enable_r) begin
            result_accumulator_r <= result_accumulator_r + ACC_W'(conv_data);
        end
    end

    // Flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= 3'h0;
        end else begin
            flag_r <= (flag_r & ((wr_fire && waddr == ADDR_FCLR && s_axi_wstrb[0]) ?
                                 s_axi_wdata[3:1] : 3'h7))
                      | {done_hit && multi_mode && total_hit,
                         done_hit && seq_mode && last_slot,
                         done_hit};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flag_r & ien_r);
        end
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module testbench import acs_pkg::*;;
    logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v, acc_exp;
    logic [3:0]  s_axi_wstrb = 4'hF, analog_input_channel;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, conv_done, irq;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, sampling_speed, wresp, rresp_v;
    logic        core_enable, conv_start;
    logic [11:0] conv_data;
    int          n_fail = 0, checks_done = 0, cyc = 0, n;
    logic [3:0]  ch_q[$];
    logic [3:0]  ch_v;
    logic [3:0]  chans[4] = '{4'h3, 4'h5, 4'h0, 4'h2};

    acs_top i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .core_enable(core_enable),
        .conv_start(conv_start), .analog_input_channel(analog_input_channel),
        .sampling_speed(sampling_speed), .conv_done(conv_done),
        .conv_data(conv_data), .irq(irq)
    );
    acs_core_model i_core (
        .aclk(aclk), .aresetn(aresetn),
        .core_enable(core_enable), .conv_start(conv_start),
        .analog_input_channel(analog_input_channel), .slow(slow),
        .conv_done(conv_done), .conv_data(conv_data)
    );

    always #4 aclk = ~aclk;
    always @(negedge aclk) if (conv_start === 1'b1) ch_q.push_back(analog_input_channel);
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            results();
        end
    end

    function automatic logic [11:0] res(input logic [3:0] ch);
        return 12'h0A0 + {8'h00, ch};
    endfunction

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do @(negedge aclk); while (s_axi_awready !== 1'b1);
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        s_axi_bready  <= 1'b1;
        do begin
            @(negedge aclk);
            wresp = s_axi_bresp;
        end while (s_axi_bvalid !== 1'b1);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        do begin
            @(negedge aclk);
            rd_v    = s_axi_rdata;
            rresp_v = s_axi_rresp;
        end while (s_axi_rvalid !== 1'b1);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK(rd_v, e)
    endtask

    task automatic wait_flag(input int b);
        do rd(ADDR_FLAG); while (rd_v[b] !== 1'b1);
    endtask

    // Ready must read low just after the enable write, then rise
    task automatic en_wait(input logic [31:0] v);
        wr(ADDR_CTRL0, v);
        rchk(ADDR_FLAG, 32'h0);
        wait_flag(FLAG_READY);
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h60);
        `CHK(rresp_v, RESP_SLVERR)
        `CHK(rd_v, 32'h0)
        wr(ADDR_FLAG, 32'h0);
        `CHK(wresp, RESP_SLVERR)
        $display("test bus errors done");
        en_wait(32'h61);
        wr(ADDR_SEQLEN, 32'h3);
        wr(ADDR_SLOTS, 32'h2053);
        wr(ADDR_CTRL2, 32'h3);
        wr(ADDR_FCLR, 32'h0);
        acc_exp = 32'h0;
        // Auto-off armed mid-sequence must still wait for the last slot
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_START, k >= 5 ? 32'h3 : 32'h1);
            wait_flag(FLAG_EOC);
            acc_exp += res(chans[k % 4]);
            ch_v = ch_q.pop_front();
            `CHK(ch_v, chans[k % 4])
            rchk(ADDR_RES0 + 8'(4 * (k % 4)), {20'h0, res(chans[k % 4])});
            rchk(ADDR_FLAG, {28'h0, 1'b0, k % 4 == 3, 1'b1, k != 7});
            rchk(ADDR_START, k >= 5 ? 32'h2 : 32'h0);
            rchk(ADDR_CTRL0, k == 7 ? 32'h60 : 32'h61);
            wr(ADDR_FCLR, 32'h0);
        end
        rchk(ADDR_ACC, acc_exp);
        $display("test intermittent done");
        slow <= 1'b1;
        en_wait(32'h51);
        wr(ADDR_SEQLEN, 32'h2);
        wr(ADDR_CTRL2, 32'h0303);
        wr(ADDR_IEN, 32'h8);
        wr(ADDR_START, 32'h3);
        wait_flag(FLAG_EOA);
        `CHK(irq, 1'b1)
        `CHK(ch_q.size(), 4)
        `CHK(ch_q[3], 4'h3)
        rchk(ADDR_FLAG, 32'hE);
        rchk(ADDR_START, 32'h2);
        rchk(ADDR_CTRL0, 32'h50);
        rchk(ADDR_CTRL2, 32'h0301);
        rchk(ADDR_ACC, res(4'h3) * 2 + res(4'h5) + res(4'h0));
        wr(ADDR_FCLR, 32'hFFFF_FFF7);
        rchk(ADDR_FLAG, 32'h6);
        `CHK(irq, 1'b0)
        wr(ADDR_FCLR, 32'h0);
        rchk(ADDR_FLAG, 32'h0);
        ch_q.delete();
        $display("test multiple done");
        slow <= 1'b0;
        en_wait(32'h21);
        wr(ADDR_START, 32'h3);
        wait_flag(FLAG_EOC);
        rchk(ADDR_CTRL0, 32'h21);
        wr(ADDR_START, 32'h2);
        do rd(ADDR_CTRL0); while (rd_v[0] !== 1'b0);
        n = ch_q.size();
        repeat (20) @(posedge aclk);
        `CHK(ch_q.size(), n)
        `CHK(n > 2, 1'b1)
        $display("test continuous done");
        ch_q.delete();
        wr(ADDR_FCLR, 32'h0);
        en_wait(32'h0D);
        `CHK(sampling_speed, 2'h3)
        wr(ADDR_START, 32'h3);
        wait_flag(FLAG_EOC);
        rchk(ADDR_CTRL0, 32'h0C);
        wr(ADDR_FCLR, 32'h0);
        en_wait(32'h31);
        wr(ADDR_START, 32'h3);
        wait_flag(FLAG_EOS);
        rchk(ADDR_CTRL0, 32'h30);
        `CHK(ch_q.size(), 4)
        wr(ADDR_FCLR, 32'h0);
        en_wait(32'h11);
        wr(ADDR_CTRL2, 32'h0103);
        wr(ADDR_START, 32'h3);
        wait_flag(FLAG_EOA);
        rchk(ADDR_CTRL0, 32'h10);
        `CHK(ch_q.size(), 6)
        wr(ADDR_FCLR, 32'h0);
        en_wait(32'h41);
        wr(ADDR_START, 32'h3);
        wait_flag(FLAG_EOS);
        rchk(ADDR_CTRL0, 32'h41);
        wr(ADDR_START, 32'h2);
        do rd(ADDR_CTRL0); while (rd_v[0] !== 1'b0);
        `CHK(rd_v, 32'h40)
        $display("test auto-off modes done");
        results();
    end
endmodule
`default_nettype wire
